/* src/hibernation_mode_manager.sv */
// hibernation mode manager: own hibernation, neighbour tracking, anchor table
`default_nettype none
`include "hib_defines.svh"
module hibernation_mode_manager
   import hib_pkg::*;
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // avalon-mm slave
   input  wire logic [3:0]       address,
   input  wire logic             read,
   input  wire logic             write,
   input  wire logic [31:0]      writedata,
   output logic [31:0]           readdata,
   output logic                  waitrequest,
   // superframe timing
   input  wire logic             sf_start,
   input  wire logic             beacon_period_window,
   input  wire logic             beacon_tx_done,
   // received beacons and slot status
   input  wire hib_pkg::rx_beacon_s rx_beacon,
   input  wire logic             former_slot_free,
   // own beacon content and transmit gating
   output hib_pkg::hib_ie_s      hib_ie,
   output logic                  tx_allowed,
   output logic                  bp_scan,
   output logic                  release_reservations,
   output logic                  reuse_slot,
   output logic                  acquire_new_slot,
   output logic                  anchor_capable,
   output logic                  anchor_ie_present,
   output logic [7:0]            anchor_entry_valid,
   // per-neighbour status
   output logic [7:0]            nbr_hibernating,
   output logic [7:0]            nbr_resv_ended,
   output logic [7:0]            unicast_hold,
   output logic [7:0]            mcast_copy_keep,
   output logic [7:0]            slot_hold,
   output logic [7:0]            slot_advertise
);
   ////////////////////////////////////////////////////////////////////////
   // helpers
   // saturating decrement, used by every countdown
   function automatic logic [7:0] dec8(input logic [7:0] v);
      dec8 = (v == 8'h00) ? 8'h00 : v - 8'h01;
   endfunction : dec8

   ////////////////////////////////////////////////////////////////////////
   // register bus
   logic        ack_reg;          // second cycle of an access
   logic [31:0] rdata_reg;        // registered read data
   logic        anchor_reg;       // anchor role enabled
   logic [15:0] cfg_reg;          // countdown and duration to announce
   logic [7:0]  lost_reg;         // lost-beacon limit
   logic [7:0]  prot_reg;         // slot-protection limit
   nbr_idx_t    sel_reg;          // neighbour shown in info word
   logic        refused_reg;      // last start refused (zero duration)
   wire  req    = read | write;
   wire  wr_acc = write & ack_reg; // write lands where waitrequest is low
   wire  hit_ctrl = address == `CTRL_IDX;
   wire  hit_cfg  = address == `HIBCFG_IDX;
   wire  hit_lim  = address == `LIMITS_IDX;
   wire  hit_sel  = address == `NBRSEL_IDX;
   wire  start_wr = wr_acc & hit_ctrl & writedata[`CTRL_START];
   wire  wake_wr  = wr_acc & hit_ctrl & writedata[`CTRL_WAKE];
   // one wait cycle per access: request seen, then answered
   assign waitrequest = req & ~ack_reg;
   assign readdata    = rdata_reg;

   // access phase tracker
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // software-writable configuration
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         anchor_reg <= 1'b0;
         cfg_reg    <= `CFG_RST;
         lost_reg   <= `LOST_RST;
         prot_reg   <= `PROT_RST;
         sel_reg    <= 3'h0;
      end else if (wr_acc) begin
         if (hit_ctrl) begin
            anchor_reg <= writedata[`CTRL_ANCHOR];
         end else if (hit_cfg) begin
            cfg_reg <= writedata[15:0];
         end else if (hit_lim) begin
            lost_reg <= writedata[`LO8];
            prot_reg <= writedata[`HI8];
         end else if (hit_sel) begin
            sel_reg <= writedata[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // own hibernation state machine
   own_state_e st_reg, st_next;
   logic [7:0] cd_reg, cd_next;     // announced countdown
   logic [7:0] left_reg, left_next; // superframes of hibernation left
   // zero duration is refused: the element must carry a non-zero length
   wire start_ok  = start_wr & (cfg_reg[`HI8] != 8'h00) & (st_reg == ST_ACTIVE);
   wire start_bad = start_wr & (cfg_reg[`HI8] == 8'h00);
   wire wake_now  = st_next == ST_ACTIVE & (st_reg == ST_HIBERNATE | st_reg == ST_SCAN);

   // next-state decision
   always_comb begin
      st_next   = st_reg;
      cd_next   = cd_reg;
      left_next = left_reg;
      case (st_reg)
         ST_ACTIVE: begin
            if (start_ok) begin
               st_next = ST_ANNOUNCE;
               cd_next = cfg_reg[`LO8];
            end
         end
         ST_ANNOUNCE: begin
            if (sf_start) begin
               if (cd_reg == 8'h00) begin
                  st_next   = ST_HIBERNATE;
                  left_next = cfg_reg[`HI8];
               end else begin
                  cd_next = dec8(cd_reg);
               end
            end
         end
         ST_HIBERNATE: begin
            if (wake_wr) begin
               st_next = ST_ACTIVE;
            end else if (sf_start) begin
               left_next = dec8(left_reg);
               // listen to beacons in the final superframes
               if (dec8(left_reg) <= `SCAN_SF) begin
                  st_next = ST_SCAN;
               end
            end
         end
         ST_SCAN: begin
            if (wake_wr) begin
               st_next = ST_ACTIVE;
            end else if (sf_start) begin
               left_next = dec8(left_reg);
               if (left_reg == 8'h00) begin
                  st_next = ST_ACTIVE;
               end
            end
         end
         default: begin
            st_next = ST_ACTIVE;
         end
      endcase
   end

   // own state registers and slot decision on wake
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg           <= ST_ACTIVE;
         cd_reg           <= 8'h00;
         left_reg         <= 8'h00;
         refused_reg      <= 1'b0;
         reuse_slot       <= 1'b0;
         acquire_new_slot <= 1'b0;
      end else begin
         st_reg   <= st_next;
         cd_reg   <= cd_next;
         left_reg <= left_next;
         if (start_wr) begin
            refused_reg <= start_bad;
         end
         // one-cycle pulses telling the beacon logic which slot to use
         reuse_slot       <= wake_now & former_slot_free;
         acquire_new_slot <= wake_now & ~former_slot_free;
      end
   end

   // reservations released one superframe ahead of silence
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         release_reservations <= 1'b0;
      end else begin
         release_reservations <= (start_ok & cfg_reg[`LO8] == 8'h00)
            | (st_reg == ST_ANNOUNCE & sf_start & cd_reg == 8'h01);
      end
   end

   // own beacon element and transmit gating
   assign hib_ie.present   = st_reg == ST_ANNOUNCE;
   assign hib_ie.countdown = cd_reg;
   assign hib_ie.duration  = cfg_reg[`HI8];
   // silent in hibernation and during the resync scan
   assign tx_allowed = st_reg == ST_ACTIVE | st_reg == ST_ANNOUNCE;
   assign bp_scan    = st_reg == ST_SCAN & beacon_period_window;

   ////////////////////////////////////////////////////////////////////////
   // neighbour table, one entry per neighbour index
   logic [7:0] ann_reg;        // hibernation announced, not yet begun
   logic [7:0] near_reg;       // countdown seen at or below the limit
   logic [7:0] hib_reg;        // neighbour is hibernating
   logic [7:0] term_reg;       // reservations ended pulse
   logic [7:0] ncd_reg  [8];   // neighbour countdown
   logic [7:0] ndur_reg [8];   // neighbour duration
   logic [7:0] nleft_reg[8];   // hibernation superframes left
   logic [7:0] prot_cnt [8];   // protection time left after expected wake
   logic [7:0] av_reg;         // anchor entry valid
   logic [7:0] wk_reg   [8];   // anchor wakeup countdown
   wire rx_ie  = rx_beacon.valid & rx_beacon.has_hib_ie;
   wire rx_pln = rx_beacon.valid & ~rx_beacon.has_hib_ie;
   wire rx_zero = rx_beacon.countdown == 8'h00;

   // per-neighbour tracking; a beacon in the same cycle as the superframe
   // strobe wins, because it is the fresher news about that neighbour
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ann_reg  <= 8'h00;
         near_reg <= 8'h00;
         hib_reg  <= 8'h00;
         term_reg <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            ncd_reg[i]   <= 8'h00;
            ndur_reg[i]  <= 8'h00;
            nleft_reg[i] <= 8'h00;
            prot_cnt[i]  <= 8'h00;
         end
      end else begin
         term_reg <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            if (rx_beacon.valid && rx_beacon.src == 3'(i)) begin
               // heard: protection ends, hibernation over
               hib_reg[i]  <= 1'b0;
               prot_cnt[i] <= 8'h00;
               ann_reg[i]  <= rx_ie;
               near_reg[i] <= rx_ie & (rx_beacon.countdown <= lost_reg);
               ncd_reg[i]  <= rx_beacon.countdown;
               ndur_reg[i] <= rx_beacon.duration;
            end else if (sf_start) begin
               if (ann_reg[i] && ncd_reg[i] == 8'h00) begin
                  // enters hibernation even if later beacons were missed
                  ann_reg[i]   <= 1'b0;
                  hib_reg[i]   <= 1'b1;
                  term_reg[i]  <= 1'b1;
                  nleft_reg[i] <= ndur_reg[i];
               end else if (ann_reg[i]) begin
                  ncd_reg[i] <= dec8(ncd_reg[i]);
               end else if (hib_reg[i]) begin
                  nleft_reg[i] <= dec8(nleft_reg[i]);
                  if (nleft_reg[i] == 8'h00) begin
                     // expected back; hold its slot for a limited time
                     hib_reg[i]  <= 1'b0;
                     prot_cnt[i] <= prot_reg;
                  end
               end else begin
                  prot_cnt[i] <= dec8(prot_cnt[i]);
               end
            end
         end
      end
   end

   // anchor table; a neighbour whose countdown was seen at or below the lost-beacon
   // limit is listed even if the zero countdown beacon itself was lost
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         av_reg <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            wk_reg[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (!anchor_reg) begin
               av_reg[i] <= 1'b0;
            end else if (rx_beacon.valid && rx_beacon.src == 3'(i)) begin
               if (rx_ie && rx_zero) begin
                  av_reg[i] <= 1'b1;
                  wk_reg[i] <= rx_beacon.duration;
               end else if (rx_pln) begin
                  av_reg[i] <= 1'b0;
               end
            end else if (beacon_tx_done && av_reg[i] && wk_reg[i] == 8'h00) begin
               av_reg[i] <= 1'b0;
            end else if (sf_start) begin
               if (!av_reg[i] && ann_reg[i] && near_reg[i] && ncd_reg[i] == 8'h00) begin
                  av_reg[i] <= 1'b1;
                  wk_reg[i] <= ndur_reg[i];
               end else if (av_reg[i]) begin
                  wk_reg[i] <= dec8(wk_reg[i]);
               end
            end
         end
      end
   end

   // neighbour status; unicast held and multicast copy kept while asleep
   assign nbr_hibernating = hib_reg;
   assign nbr_resv_ended  = term_reg;
   assign unicast_hold    = hib_reg;
   assign mcast_copy_keep = hib_reg;
   // held as occupied while asleep and during protection
   assign slot_hold = hib_reg | nbr_prot_v;
   // address advertised only while hibernating, even if slot reused
   assign slot_advertise = hib_reg;
   logic [7:0] nbr_prot_v;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         nbr_prot_v[i] = prot_cnt[i] != 8'h00;
      end
   end

   // anchor element only when it has entries
   assign anchor_capable     = anchor_reg;
   assign anchor_entry_valid = av_reg;
   assign anchor_ie_present  = anchor_reg & |av_reg;

   ////////////////////////////////////////////////////////////////////////
   // read data
   wire [31:0] ctrl_rd   = {31'h0, anchor_reg};
   wire [31:0] cfg_rd    = {16'h0, cfg_reg};
   wire [31:0] lim_rd    = {16'h0, prot_reg, lost_reg};
   wire [31:0] stat_rd   = {av_reg, hib_reg, 3'h0, refused_reg, st_reg, cd_reg};
   wire [31:0] sel_rd    = {29'h0, sel_reg};
   wire [31:0] info_rd   = {prot_cnt[sel_reg], wk_reg[sel_reg],
                            nleft_reg[sel_reg], ncd_reg[sel_reg]};
   logic [31:0] rd_mux;
   // unmapped addresses read as zero
   always_comb begin
      if (address == `CTRL_IDX) begin
         rd_mux = ctrl_rd;
      end else if (address == `HIBCFG_IDX) begin
         rd_mux = cfg_rd;
      end else if (address == `LIMITS_IDX) begin
         rd_mux = lim_rd;
      end else if (address == `STATUS_IDX) begin
         rd_mux = stat_rd;
      end else if (address == `NBRSEL_IDX) begin
         rd_mux = sel_rd;
      end else if (address == `NBRINFO_IDX) begin
         rd_mux = info_rd;
      end else begin
         rd_mux = 32'h0;
      end
   end

   // capture read data in the wait cycle, valid when waitrequest drops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0;
      end else if (read & ~ack_reg) begin
         rdata_reg <= rd_mux;
      end
   end
endmodule : hibernation_mode_manager
`default_nettype wire

/* src/hib_defines.svh */
// offsets, field positions, reset values and timing counts for the hibernation manager
`ifndef HIB_DEFINES_SVH
`define HIB_DEFINES_SVH
// register word indices on the avalon address
`define CTRL_IDX      4'h0
`define HIBCFG_IDX    4'h1
`define LIMITS_IDX    4'h2
`define STATUS_IDX    4'h3
`define NBRSEL_IDX    4'h4
`define NBRINFO_IDX   4'h5
// ctrl fields
`define CTRL_ANCHOR   0
`define CTRL_START    1
`define CTRL_WAKE     2
// field positions inside 32-bit words
`define LO8           7:0
`define HI8           15:8
`define B2            23:16
`define B3            31:24
// reset values
`define LOST_RST      8'h03
`define PROT_RST      8'h04
`define CFG_RST       16'h0000
// superframes left when beacon scanning starts; the scan runs this many plus one before own wake
`define SCAN_SF       8'h02
`endif

/* src/hib_pkg.sv */
// types shared by the hibernation manager and its users
`default_nettype none
package hib_pkg;
   // one-hot own power-management mode
   typedef enum logic [3:0] {
      ST_ACTIVE = 4'b0001,
      ST_ANNOUNCE = 4'b0010,
      ST_HIBERNATE = 4'b0100,
      ST_SCAN = 4'b1000
   } own_state_e;
   typedef logic [2:0] nbr_idx_t;
   // one received neighbour beacon, pulsed for one cycle
   typedef struct packed {
      logic     valid;
      nbr_idx_t src;
      logic     has_hib_ie;
      logic [7:0] countdown;
      logic [7:0] duration;
   } rx_beacon_s;
   // hibernation element to place in our own beacon
   typedef struct packed {
      logic       present;
      logic [7:0] countdown;
      logic [7:0] duration;
   } hib_ie_s;
endpackage : hib_pkg
`default_nettype wire

/* test/hib_props.sv */
// checker: port relations of the hibernation manager
`default_nettype none
module hib_props
   import hib_pkg::*;
(
   // clock, reset and bus
   input wire logic                mclk,
   input wire logic                rst_n,
   input wire logic                read,
   input wire logic                write,
   input wire logic                waitrequest,
   // timing and received beacons
   input wire logic                sf_start,
   input wire logic                beacon_period_window,
   input wire logic                former_slot_free,
   input wire hib_pkg::rx_beacon_s rx_beacon,
   // own and neighbour status
   input wire hib_pkg::hib_ie_s    hib_ie,
   input wire logic                tx_allowed,
   input wire logic                bp_scan,
   input wire logic                reuse_slot,
   input wire logic                acquire_new_slot,
   input wire logic                anchor_capable,
   input wire logic                anchor_ie_present,
   input wire logic [7:0]          anchor_entry_valid,
   input wire logic [7:0]          nbr_hibernating,
   input wire logic [7:0]          nbr_resv_ended,
   input wire logic [7:0]          unicast_hold,
   input wire logic [7:0]          mcast_copy_keep,
   input wire logic [7:0]          slot_hold,
   input wire logic [7:0]          slot_advertise
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // at most one wait cycle per transfer
   chk_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest held past one cycle");
   // scanning only in the beacon period and never on air
   chk_scan_quiet: assert property (bp_scan |-> beacon_period_window && !tx_allowed)
      else $error("scan outside window or while transmitting");
   // slot choice follows the free flag seen at wake
   chk_slot_pick: assert property ((reuse_slot || acquire_new_slot) |->
      (reuse_slot ^ acquire_new_slot) && (reuse_slot == $past(former_slot_free)))
      else $error("wrong slot choice on wake");
   // reservations end only on a superframe strobe, for hibernating neighbours
   chk_resv_end: assert property ((nbr_resv_ended != 8'h00) |->
      $past(sf_start) && ((nbr_resv_ended & ~nbr_hibernating) == 8'h00))
      else $error("reservation end out of step");
   chk_hold_mirror: assert property (unicast_hold == nbr_hibernating && mcast_copy_keep == nbr_hibernating)
      else $error("traffic hold differs from hibernation set");
   chk_slot_advert: assert property (slot_advertise == nbr_hibernating &&
      (slot_hold & nbr_hibernating) == nbr_hibernating)
      else $error("slot of hibernating neighbour not held");
   chk_anchor_ie: assert property (anchor_ie_present == (anchor_capable && anchor_entry_valid != 8'h00))
      else $error("anchor element presence wrong");
   chk_anchor_off: assert property (!anchor_capable |-> anchor_entry_valid == 8'h00)
      else $error("entries kept without anchor role");
   chk_ie_nonzero: assert property (hib_ie.present |-> hib_ie.duration != 8'h00)
      else $error("announced zero duration");
   chk_anchor_add: assert property (rx_beacon.valid && rx_beacon.has_hib_ie && anchor_capable &&
      rx_beacon.countdown == 8'h00 |=> anchor_entry_valid[$past(rx_beacon.src)])
      else $error("anchor entry not added");
   chk_early_drop: assert property (rx_beacon.valid && !rx_beacon.has_hib_ie |=>
      !anchor_entry_valid[$past(rx_beacon.src)] && !nbr_hibernating[$past(rx_beacon.src)])
      else $error("entry kept after neighbour beacon");
endmodule : hib_props
`default_nettype wire

/* test/nbr_model.sv */
// neighbour devices: superframe timing, own beacon slot and received beacons
`default_nettype none
module nbr_model
   import hib_pkg::*;
#(
   parameter int SF_LEN = 32
)(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // beacon asked for by the bench
   input  wire logic          send,
   input  wire logic [2:0]    src,
   input  wire logic          with_ie,
   input  wire logic [7:0]    cd,
   input  wire logic [7:0]    dur,
   // timing and beacon towards the block
   output logic               sf_start,
   output logic               beacon_period_window,
   output logic               beacon_tx_done,
   output hib_pkg::rx_beacon_s rx_beacon
);
   logic [7:0] cnt_reg; // position inside the superframe
   logic       fire;    // a neighbour beacon airs now
   ////////////////////////////////////////////////////////////////////////////////
   // free running superframe counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= (cnt_reg == 8'(SF_LEN - 1)) ? 8'h00 : cnt_reg + 8'h01;
      end
   end
   // one strobe per superframe, beacon period right after it
   assign sf_start             = rst_n && (cnt_reg == 8'h00);
   assign beacon_period_window = (cnt_reg >= 8'h01) && (cnt_reg <= 8'h06);
   assign beacon_tx_done       = (cnt_reg == 8'h05);
   assign fire                 = send && (cnt_reg == 8'h03);
   // off air the fields churn so stale values cannot pass for a beacon
   assign rx_beacon = fire ? {1'b1, src, with_ie, cd, dur}
                           : {1'b0, cnt_reg[2:0], cnt_reg[0], cnt_reg, ~cnt_reg};
endmodule : nbr_model
`default_nettype wire

/* test/tb_hibernation_mode_manager.sv */
// bench: avalon master, read scoreboard and neighbour scenarios
`default_nettype none
module tb_hibernation_mode_manager;
   timeunit 1ns;
   timeprecision 1ns;
   import hib_pkg::*;
   logic        mclk = 1'b0;       // 25 mhz clock
   logic        rst_n = 1'b0;      // held low for five cycles
   logic [3:0]  address = 4'h0;    // bus request
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        sf_start;          // from the neighbour model
   logic        beacon_period_window;
   logic        beacon_tx_done;
   rx_beacon_s  rx_beacon;
   logic        former_slot_free = 1'b0;
   logic        send = 1'b0;       // beacon request to the model
   logic [2:0]  src = 3'h0;
   logic        with_ie = 1'b0;
   logic [7:0]  cd = 8'h00;
   logic [7:0]  dur = 8'h00;
   logic [31:0] exp_q[$];          // expected read words
   logic [31:0] mask_q[$];         // bits that matter per read
   int          mismatches = 0;
   int          checked = 0;
   int          seed = 71995;
   always #20 mclk = ~mclk;
   hibernation_mode_manager dut (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .sf_start(sf_start), .beacon_period_window(beacon_period_window),
      .beacon_tx_done(beacon_tx_done), .rx_beacon(rx_beacon),
      .former_slot_free(former_slot_free), .hib_ie(), .tx_allowed(), .bp_scan(),
      .release_reservations(), .reuse_slot(), .acquire_new_slot(), .anchor_capable(),
      .anchor_ie_present(), .anchor_entry_valid(), .nbr_hibernating(), .nbr_resv_ended(),
      .unicast_hold(), .mcast_copy_keep(), .slot_hold(), .slot_advertise());
   nbr_model #(.SF_LEN(32)) far (.mclk(mclk), .rst_n(rst_n), .send(send), .src(src),
      .with_ie(with_ie), .cd(cd), .dur(dur), .sf_start(sf_start),
      .beacon_period_window(beacon_period_window), .beacon_tx_done(beacon_tx_done),
      .rx_beacon(rx_beacon));
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   // one transfer held until waitrequest is seen low; a read notes its expectation
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] m);
      @(posedge mclk);
      if (!wr) begin
         exp_q.push_back(d);
         mask_q.push_back(m);
      end
      address   <= a;
      writedata <= wr ? d : 32'h0;
      write     <= wr;
      read      <= !wr;
      @(posedge mclk);
      while (waitrequest !== 1'b0) @(posedge mclk);
      write <= 1'b0;
      read  <= 1'b0;
   endtask : bus
   // wait for a superframe strobe, then a few cycles more
   task automatic next_sf(input int gap);
      @(posedge mclk);
      while (sf_start !== 1'b1) @(posedge mclk);
      repeat (gap) @(posedge mclk);
   endtask : next_sf
   // one neighbour beacon in the coming beacon period
   task automatic beacon(input logic [2:0] s, input logic ie, input logic [7:0] c,
                         input logic [7:0] d);
      next_sf(0);
      src     <= s;
      with_ie <= ie;
      cd      <= c;
      dur     <= d;
      send    <= 1'b1;
      repeat (4) @(posedge mclk);
      send <= 1'b0;
   endtask : beacon
   // scoreboard: each completed read takes the oldest note
   always @(posedge mclk) begin
      if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
         checked++;
         if ((readdata & mask_q[0]) !== (exp_q[0] & mask_q[0])) begin
            mismatches++;
            $display("BAD t=%0t got %h expected %h", $time, readdata, exp_q[0]);
         end
         void'(exp_q.pop_front());
         void'(mask_q.pop_front());
      end
   end
   // hang guard, far beyond the expected run of about twenty superframes
   initial begin
      #400000;
      mismatches++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] c, d, left;
      logic [3:0] st, a;
      logic [2:0] s;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      // reset values, limits and an unmapped word
      bus(0, 4'h0, 32'h0, 32'hffffffff);
      bus(0, 4'h2, 32'h0403, 32'hffffffff);
      bus(0, 4'h3, 32'h0100, 32'hffffffff);
      bus(1, 4'h2, 32'h0503, 32'h0);
      bus(0, 4'h2, 32'h0503, 32'hffff);
      a = 4'h6 + 4'($unsigned($random(seed)) % 10);
      bus(1, a, $random(seed), 32'h0);
      bus(0, a, 32'h0, 32'hffffffff);
      // zero duration is refused
      bus(1, 4'h1, 32'h0001, 32'h0);
      bus(1, 4'h0, 32'h2, 32'h0);
      bus(0, 4'h3, 32'h1100, 32'h1f00);
      // announce, count down, hibernate, scan and wake on schedule
      c = 8'($unsigned($random(seed)) % 3) + 8'h01;
      d = 8'($unsigned($random(seed)) % 4) + 8'h03;
      former_slot_free <= ($random(seed) & 1) != 0;
      bus(1, 4'h1, {16'h0, d, c}, 32'h0);
      bus(1, 4'h0, 32'h2, 32'h0);
      bus(0, 4'h3, {20'h0, 4'h2, c}, 32'h0fff);
      st = 4'h2;
      left = 8'h00;
      while (st != 4'h1) begin
         next_sf(2);
         if (st == 4'h2 && c != 8'h00) begin
            c = c - 8'h01;
         end else if (st == 4'h2) begin
            st = 4'h4;
            left = d;
         end else if (st == 4'h4) begin
            left = left - 8'h01;
            st = (left <= 8'h02) ? 4'h8 : 4'h4;
         end else if (left == 8'h00) begin
            st = 4'h1;
         end else begin
            left = left - 8'h01;
         end
         bus(0, 4'h3, {20'h0, st, c}, (st == 4'h2) ? 32'h0fff : 32'h0f00);
      end
      // early wake by software while hibernating
      bus(1, 4'h1, 32'h1400, 32'h0);
      bus(1, 4'h0, 32'h2, 32'h0);
      next_sf(2);
      bus(0, 4'h3, 32'h0400, 32'h0f00);
      bus(1, 4'h0, 32'h4, 32'h0);
      bus(0, 4'h3, 32'h0100, 32'h0f00);
      // neighbour near the lost beacon limit then silent
      bus(1, 4'h0, 32'h1, 32'h0);
      bus(0, 4'h0, 32'h1, 32'h1);
      s = 3'($unsigned($random(seed)) % 7);
      beacon(s, 1'b1, 8'h02, 8'h09);
      next_sf(0);
      next_sf(2);
      bus(0, 4'h3, 32'h0, 32'hffff0000);
      next_sf(2);
      bus(0, 4'h3, {{2{8'h01 << s}}, 16'h0}, 32'hffff0000);
      // its early beacon drops it everywhere
      beacon(s, 1'b0, 8'h00, 8'h00);
      bus(0, 4'h3, 32'h0, 32'hffff0000);
      // direct entry, counted down, shown at zero, then deleted
      beacon(s + 3'h1, 1'b1, 8'h00, 8'h02);
      bus(0, 4'h3, {8'h01 << (s + 3'h1), 24'h0}, 32'hff000000);
      next_sf(8);
      bus(0, 4'h3, {8'h01 << (s + 3'h1), 24'h0}, 32'hff000000);
      next_sf(8);
      bus(0, 4'h3, 32'h0, 32'hff000000);
      // anchor role given up
      bus(1, 4'h0, 32'h0, 32'h0);
      bus(0, 4'h0, 32'h0, 32'h1);
      conclude();
   end
endmodule : tb_hibernation_mode_manager
bind hibernation_mode_manager hib_props chk (.mclk(mclk), .rst_n(rst_n), .read(read),
   .write(write), .waitrequest(waitrequest), .sf_start(sf_start),
   .beacon_period_window(beacon_period_window), .former_slot_free(former_slot_free),
   .rx_beacon(rx_beacon), .hib_ie(hib_ie), .tx_allowed(tx_allowed), .bp_scan(bp_scan),
   .reuse_slot(reuse_slot), .acquire_new_slot(acquire_new_slot),
   .anchor_capable(anchor_capable), .anchor_ie_present(anchor_ie_present),
   .anchor_entry_valid(anchor_entry_valid), .nbr_hibernating(nbr_hibernating),
   .nbr_resv_ended(nbr_resv_ended), .unicast_hold(unicast_hold),
   .mcast_copy_keep(mcast_copy_keep), .slot_hold(slot_hold), .slot_advertise(slot_advertise));
`default_nettype wire
